// File: dhs_suspend_ctrl.sv
// emulation suspend control for the decoder coprocessor
`timescale 1ns/10ps
`include "dhs_defs.svh"

// What this block does
// [R1] upper thirty control bits read zero, ignored
// [R2] ignore-halt bit set: run through halt
// [R3] ignore-halt clear: halt per select bit
// [R4] select 0: halt after pass or frame
// [R5] select 1: halt only before final write
// [R6] drain bus and pending requests first
// [R7] finish asserted sync events and pass
// [R8] pass mode: no new events while halted
// [R9] release resumes from halted state normally
// [R10] frame mode: hold next frame sync events
// [R11] state 14 ignores request until state 0
// [R12] state 0 or 1 acknowledges without DMA
// [R13] acknowledged state 1 masks access errors
// [R14] realtime suspend unused, bit 2 reserved
// [R15] status bit 10 shows debug halt
// [R16] status bits 27:24 show top state
// [R17] control register at address 0x00070
// [R18] request is a level, held while high
module dhs_suspend_ctrl
    import dhs_pkg::*;
(
    input wire logic clk_in, // core clock, 100 MHz
    input wire logic srst_in, // synchronous reset
    input wire logic cfg_wr_in, // config bus write strobe
    input wire logic cfg_rd_in, // config bus read strobe
    input wire logic [`DHS_CFG_AW-1:0] cfg_addr_in, // config bus address
    input wire logic [31:0] cfg_wdata_in, // config bus write data
    output logic [31:0] cfg_rdata_out, // control register readback
    output logic [31:0] status_word_out, // halt flag and top state
    input wire logic emu_suspend_in, // cpu emulation halt request pin
    input wire logic realtime_suspend_input, // realtime suspend, unused
    output logic emu_ack_out, // suspend acknowledge
    input wire logic [3:0] core_state_in, // decoder top-level state
    input wire logic pass_end_in, // decoding pass finished
    input wire logic frame_end_in, // decode done, before final write event
    input wire logic frame_start_in, // core wants to start next frame
    input wire logic bus_busy_in, // bus transfer in progress
    input wire logic req_pending_in, // cpu or dma request pending
    input wire logic dma_active_in, // dma transaction active
    input wire logic read_sync_req_in, // core raises read event
    input wire logic write_sync_req_in, // core raises write event
    input wire logic mem_err_in, // memory access error from core
    input wire logic int_req_in, // coprocessor interrupt from core
    output logic read_sync_event_out, // read event to cpu or dma
    output logic write_sync_event_out, // write event to cpu or dma
    output logic core_stall_out, // pause decoder core
    output logic frame_start_ok_out, // next frame may begin
    output logic mem_err_out, // gated memory access error
    output logic int_out // gated coprocessor interrupt
);
    // ****************************************
    // control register
    // ****************************************
    logic [1:0] ctrl_q;
    wire ctrl_hit = (cfg_addr_in == `DHS_CTRL_ADDR); // [R17]
    wire ctrl_wr = cfg_wr_in && ctrl_hit;
    wire free_bit = ctrl_q[`DHS_FREE_BIT];
    wire soft_bit = ctrl_q[`DHS_SOFT_BIT];
    logic [31:0] rdata_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_q <= `DHS_CTRL_RESET;
        end else if (ctrl_wr) begin
            // bit 2 and above dropped on write
            ctrl_q <= cfg_wdata_in[1:0]; // [R1] [R14]
        end
    end

    // unmapped reads return zero
    wire [31:0] rd_word = ctrl_hit ? {30'h0, ctrl_q} : 32'h0; // [R1]

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_q <= 32'h0;
        end else if (cfg_rd_in) begin
            rdata_q <= rd_word;
        end
    end

    assign cfg_rdata_out = rdata_q;

    // ****************************************
    // request synchronisation
    // ****************************************
    logic susp_level;

    dhs_pin_sync u_susp_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in(emu_suspend_in),
        .level_out(susp_level)
    );

    // ****************************************
    // halt sequencing
    // ****************************************
    dhs_state_t state_q;
    dhs_state_t state_d;
    logic sync_busy_q;
    logic ack_q;
    logic frame_held_q;

    wire halt_req = susp_level && !free_bit; // [R2] [R3]
    wire drained = !bus_busy_in && !req_pending_in && !sync_busy_q; // [R6] [R7]
    wire top_ok = (core_state_in == `DHS_TOP_IDLE) || (core_state_in == `DHS_TOP_FIRST); // [R12]
    wire top_skip = (core_state_in == `DHS_TOP_LAST); // [R11]
    // pass end or frame end stops in pass mode; frame mode waits for the frame
    wire stop_point = soft_bit ? frame_end_in : (pass_end_in || frame_end_in); // [R4] [R5]
    wire halted = (state_q == DHS_HALTED);
    wire stalling = (state_q == DHS_DRAIN) || halted;

    always_comb begin
        state_d = state_q;
        case (state_q)
            DHS_RUN: begin
                if (halt_req && !top_skip && (stop_point || (soft_bit && frame_held_q))) begin // [R7] [R10]
                    state_d = DHS_DRAIN;
                end
            end
            DHS_DRAIN: begin
                if (!halt_req) begin
                    state_d = DHS_RUN;
                end else if (drained && top_ok && !dma_active_in) begin // [R6] [R12]
                    state_d = DHS_HALTED;
                end
            end
            DHS_HALTED: begin
                if (!susp_level) begin // [R18]
                    state_d = DHS_RESUME;
                end
            end
            DHS_RESUME: begin
                state_d = DHS_RUN; // [R9]
            end
            default: begin
                state_d = DHS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= DHS_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // an event already raised before the halt is still let out
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync_busy_q <= 1'b0;
        end else begin
            sync_busy_q <= (read_sync_req_in || write_sync_req_in) && !halted; // [R7]
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (state_d == DHS_HALTED); // [R12] [R18]
        end
    end

    // frame mode: a new frame is held while the request stands
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            frame_held_q <= 1'b0;
        end else if (!halt_req || !soft_bit) begin
            frame_held_q <= 1'b0;
        end else if (frame_end_in) begin
            frame_held_q <= 1'b1; // [R10]
        end
    end

    // ****************************************
    // outputs to core and partner
    // ****************************************
    logic rd_evt_q;
    logic wr_evt_q;
    logic err_q;
    logic int_q;
    wire mask_mem = ack_q && (core_state_in == `DHS_TOP_FIRST); // [R13]

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_evt_q <= 1'b0;
            wr_evt_q <= 1'b0;
            err_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            rd_evt_q <= read_sync_req_in && !halted; // [R8]
            wr_evt_q <= write_sync_req_in && !halted; // [R8]
            err_q <= mem_err_in && !mask_mem; // [R13]
            int_q <= int_req_in && !mask_mem; // [R13]
        end
    end

    assign read_sync_event_out = rd_evt_q;
    assign write_sync_event_out = wr_evt_q;
    assign mem_err_out = err_q;
    assign int_out = int_q;
    assign emu_ack_out = ack_q;
    assign core_stall_out = halted || (stalling && drained); // [R4]
    assign frame_start_ok_out = frame_start_in && !frame_held_q && !halted; // [R10]

    // ****************************************
    // status
    // ****************************************
    logic [31:0] status_q;

    // realtime input deliberately left unread
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_q <= 32'h0;
        end else begin
            status_q <= 32'h0;
            // taken from the next state so the flag moves with the acknowledge
            status_q[`DHS_ST_HALT_BIT] <= (state_d == DHS_HALTED); // [R15]
            status_q[`DHS_ST_STATE_LSB +: 4] <= core_state_in; // [R16]
        end
    end

    assign status_word_out = status_q;
endmodule

// File: dhs_defs.svh
// offsets, field positions, reset values and codes for the debug halt suspend block
`ifndef DHS_DEFS_SVH
`define DHS_DEFS_SVH
`define DHS_CTRL_ADDR 20'h00070
`define DHS_CFG_AW 20
`define DHS_FREE_BIT 0
`define DHS_SOFT_BIT 1
`define DHS_CTRL_RESET 2'h0
`define DHS_CTRL_WMASK 32'h0000_0003
`define DHS_ST_HALT_BIT 10
`define DHS_ST_STATE_LSB 24
`define DHS_TOP_IDLE 4'h0
`define DHS_TOP_FIRST 4'h1
`define DHS_TOP_LAST 4'he
`define DHS_SYNC_STAGES 3
`endif

// File: dhs_pkg.sv
// types for the debug halt suspend block
package dhs_pkg;
    typedef enum logic [2:0] {
        DHS_RUN,
        DHS_DRAIN,
        DHS_HALTED,
        DHS_RESUME
    } dhs_state_t;
endpackage

// File: dhs_pin_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
module dhs_pin_sync (
    input wire logic clk_in, // core clock
    input wire logic srst_in, // synchronous reset
    input wire logic pin_in, // asynchronous level
    output logic level_out // filtered level
);
    logic [2:0] stage_q;
    logic level_q;
    wire agree = (stage_q[1] == stage_q[2]);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            stage_q <= {stage_q[1:0], pin_in};
            if (agree) begin
                level_q <= stage_q[2];
            end
        end
    end

    assign level_out = level_q;
endmodule

// File: dhs_suspend_chk.sv
// checker for the debug halt suspend control ports
`timescale 1ns/10ps
module dhs_suspend_chk (
    input wire logic clk_in, // clock
    input wire logic srst_in, // reset
    input wire logic [31:0] cfg_rdata_out, // readback
    input wire logic [31:0] status_word_out, // status
    input wire logic emu_suspend_in, // halt pin
    input wire logic emu_ack_out, // ack
    input wire logic [3:0] core_state_in, // top state
    input wire logic bus_busy_in, // bus busy
    input wire logic req_pending_in, // pending
    input wire logic dma_active_in, // dma
    input wire logic write_sync_event_out, // event
    input wire logic mem_err_out // error
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // ****
    // assertions
    // ****
    a_rsvd_zero: assert property (cfg_rdata_out[31:2] == 30'h0)
        else $error("reserved bits set");
    a_flag_tracks: assert property (status_word_out[10] == emu_ack_out)
        else $error("halt flag wrong");
    a_state_copy: assert property (!$past(srst_in) |-> status_word_out[27:24] == $past(core_state_in))
        else $error("state field wrong");
    a_drain_first: assert property ($rose(emu_ack_out) |-> $past(!bus_busy_in && !req_pending_in))
        else $error("halt with traffic");
    a_idle_ack: assert property ($rose(emu_ack_out) |->
        $past(core_state_in) <= 4'h1 && !$past(dma_active_in)) else $error("ack outside idle");
    a_top_blocks: assert property (core_state_in == 4'he && !emu_ack_out |=> !emu_ack_out)
        else $error("ack in state 14");
    a_no_event: assert property (emu_ack_out && $past(emu_ack_out) |-> !write_sync_event_out)
        else $error("event while halted");
    a_err_masked: assert property ($past(emu_ack_out) && $past(core_state_in) == 4'h1 |-> !mem_err_out)
        else $error("error not masked");
    // depth 4 spans the whole synchroniser, so a one-sample pin dip cannot satisfy it
    a_level_hold: assert property ($fell(emu_ack_out) |-> !$past(emu_suspend_in, 4))
        else $error("ack dropped early");
    c_halt: cover property ($rose(emu_ack_out));
    c_masked: cover property (emu_ack_out && core_state_in == 4'h1);
    c_release: cover property ($fell(emu_ack_out));
endmodule
bind dhs_suspend_ctrl dhs_suspend_chk dhs_suspend_chk_inst (.clk_in, .srst_in, .cfg_rdata_out, .status_word_out,
    .emu_suspend_in, .emu_ack_out, .core_state_in, .bus_busy_in, .req_pending_in, .dma_active_in,
    .write_sync_event_out, .mem_err_out);

// File: dhs_host_model.sv
// host side bus and dma traffic model
`timescale 1ns/10ps
module dhs_host_model (
    input wire logic clk_in, // clock
    input wire logic [3:0] len_in, // new transfer length
    output logic busy_out, // bus transfer
    output logic pend_out, // request queued
    output logic dma_out // dma in flight
);
    logic [3:0] left_q = 4'h0;
    // a started transfer always runs out before a new one
    always @(posedge clk_in) left_q <= (left_q != 4'h0) ? left_q - 4'h1 : len_in;
    assign busy_out = left_q != 4'h0;
    assign pend_out = left_q > 4'h1;
    assign dma_out = left_q > 4'h2;
endmodule

// File: tb_dhs_suspend_ctrl.sv
// self-checking bench for the debug halt suspend control
`timescale 1ns/10ps
module tb_dhs_suspend_ctrl;
    logic clk_in = 1'h0, srst_in = 1'h1, wr = 1'h0, rd = 1'h0, halt = 1'h0, pass = 1'h0, fend = 1'h0;
    logic fst = 1'h0, sreq = 1'h0, err = 1'h0, ack, wevt, revt, merr, ierr, fok, busy, qp, dma, stall;
    logic rt = 1'h0;
    logic [19:0] addr = 20'h0;
    logic [31:0] wdata = 32'h0, rdata, status;
    logic [3:0] state = 4'h0, len = 4'h0;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    always #5 clk_in = ~clk_in;
    dhs_host_model dhs_host_model_inst (.clk_in, .len_in(len), .busy_out(busy), .pend_out(qp), .dma_out(dma));
    dhs_suspend_ctrl dhs_suspend_ctrl_inst (.clk_in, .srst_in, .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(addr),
        .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .status_word_out(status), .emu_suspend_in(halt),
        .realtime_suspend_input(rt), .emu_ack_out(ack), .core_state_in(state), .pass_end_in(pass),
        .frame_end_in(fend), .frame_start_in(fst), .bus_busy_in(busy), .req_pending_in(qp), .dma_active_in(dma),
        .read_sync_req_in(sreq), .write_sync_req_in(sreq), .mem_err_in(err), .int_req_in(err),
        .read_sync_event_out(revt), .write_sync_event_out(wevt), .core_stall_out(stall), .frame_start_ok_out(fok),
        .mem_err_out(merr), .int_out(ierr));
    // ****
    // shared tasks
    // ****
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
        addr = a;
        rd = 1'h1;
        cyc(1);
        rd = 1'h0;
        cyc(1);
        check(rdata, exp);
    endtask
    task automatic wait_ack(input logic v);
        for (int i = 0; i < 30 && ack !== v; i++) cyc(1);
        check(32'(ack), 32'(v));
    endtask
    task automatic wr_ctrl(input logic [31:0] c);
        addr = 20'h00070;
        wdata = c;
        wr = 1'h1;
        cyc(1);
        wr = 1'h0;
    endtask
    // pin is synchronised over three flops, so the stop point comes late
    task automatic arm(input logic [31:0] c);
        wr_ctrl(c);
        halt = 1'h1;
        cyc(6);
        pass = 1'h1;
        cyc(1);
        pass = 1'h0;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        arm(32'hffff_ffff);
        halt = 1'h0;
        rd_chk(20'h00070, 32'h3);
        rd_chk(20'h00074, 32'h0);
        $display("regs done");
    endtask
    task automatic t_pass;
        state = 4'he;
        arm(32'h0);
        cyc(10);
        check(32'(ack), 32'h0);
        len = 4'h9;
        cyc(1);
        len = 4'h0;
        state = 4'h0;
        pass = 1'h1;
        cyc(1);
        pass = 1'h0;
        check(32'(ack), 32'h0);
        cyc(8);
        // host traffic has only just run out here
        check(32'(ack), 32'h0);
        pass = 1'h1;
        cyc(1);
        pass = 1'h0;
        wait_ack(1'h1);
        check(32'(status[10]), 32'h1);
        state = 4'h1;
        sreq = 1'h1;
        err = 1'h1;
        cyc(3);
        check({27'h0, stall, wevt, revt, merr, ierr}, 32'h10);
        check(32'(status[27:24]), 32'h1);
        state = 4'h0;
        halt = 1'h0;
        wait_ack(1'h0);
        cyc(3);
        check({28'h0, stall, wevt, merr, ierr}, 32'h7);
        sreq = 1'h0;
        err = 1'h0;
        $display("pass halt done");
    endtask
    task automatic t_frame;
        arm(32'h2);
        cyc(6);
        check(32'(ack), 32'h0);
        fend = 1'h1;
        cyc(1);
        fend = 1'h0;
        wait_ack(1'h1);
        fst = 1'h1;
        cyc(1);
        check(32'(fok), 32'h0);
        halt = 1'h0;
        wait_ack(1'h0);
        cyc(2);
        check(32'(fok), 32'h1);
        fst = 1'h0;
        arm(32'h1);
        cyc(10);
        check(32'(ack), 32'h0);
        halt = 1'h0;
        // let the synchronised pin fall before clearing the ignore bit
        cyc(6);
        wr_ctrl(32'h4);
        rt = 1'h1;
        pass = 1'h1;
        fend = 1'h1;
        cyc(1);
        pass = 1'h0;
        fend = 1'h0;
        cyc(6);
        check(32'(ack), 32'h0);
        rt = 1'h0;
        rd_chk(20'h00070, 32'h0);
        $display("frame and free done");
    endtask
    initial begin
        cyc(4);
        srst_in = 1'h0;
        t_regs();
        t_pass();
        t_frame();
        test_done();
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            test_done();
        end
    end
endmodule
